// ==== mfc_defs.svh ====
// Named constants for the multiply and program-flow execution block.
// Assumes it is included by its bare name before any use of these macros.
`ifndef MFC_DEFS_SVH
`define MFC_DEFS_SVH

// Flag positions inside the flags register.
`define MFC_FLAG_C 0
`define MFC_FLAG_Z 1
`define MFC_FLAG_N 2
`define MFC_FLAG_V 3
`define MFC_FLAG_S 4
`define MFC_FLAG_H 5
`define MFC_FLAG_T 6
`define MFC_FLAG_I 7

// Register offsets on the software port.
`define MFC_REG_CTRL 3'h0
`define MFC_REG_FLAGS 3'h1
`define MFC_REG_STATUS 3'h2
`define MFC_REG_PC_LO 3'h3
`define MFC_REG_PC_HI 3'h4

// Field positions in the control and status registers.
`define MFC_CTRL_WIDE 0
`define MFC_CTRL_CLR_ERR 1
`define MFC_STAT_BUSY 0
`define MFC_STAT_ERR 1

// Execution lengths in clock cycles.
`define MFC_CYC_ONE 3'h1
`define MFC_CYC_TWO 3'h2
`define MFC_CYC_THREE 3'h3
`define MFC_CYC_FOUR 3'h4
`define MFC_CNT_LAST 2'h1

// Program counter steps, in instruction words.
`define MFC_PC_STEP1 16'h0001
`define MFC_PC_STEP2 16'h0002
`define MFC_PC_STEP3 16'h0003

// Reset values.
`define MFC_PC_RESET 16'h0000
`define MFC_FLAGS_RESET 8'h00
`define MFC_CTRL_WIDE_RESET 1'h0

`endif

// ==== mfc_pkg.sv ====
// Types shared by the multiply and program-flow execution block.
// Assumes the decoder upstream presents one operation code per start strobe.
package mfc_pkg;

  typedef enum logic [5:0] {
    op_product_unsigned, op_product_signed, op_product_mixed_sign,
    op_fraction_product_unsigned, op_fraction_product_signed, op_fraction_product_mixed_sign,
    op_relative_jump, op_indirect_jump, op_direct_jump,
    op_relative_subroutine_entry, op_indirect_subroutine_entry, op_direct_subroutine_entry,
    op_subroutine_exit, op_interrupt_exit,
    op_compare_skip_equal, op_compare_regs, op_compare_with_borrow, op_compare_immediate,
    op_skip_if_reg_bit_clear, op_skip_if_reg_bit_set, op_skip_if_io_bit_clear, op_skip_if_io_bit_set,
    op_branch_on_flag_set, op_branch_on_flag_clear,
    op_branch_equal, op_branch_not_equal, op_branch_carry_set, op_branch_carry_clear,
    op_branch_unsigned_ge, op_branch_unsigned_lt, op_branch_negative, op_branch_nonnegative,
    op_branch_signed_ge, op_branch_signed_lt, op_branch_half_carry_set, op_branch_half_carry_clear,
    op_branch_transfer_bit_set, op_branch_transfer_bit_clear, op_other
  } mfc_op_e;

  typedef enum logic [0:0] {
    fsm_idle, fsm_run
  } mfc_fsm_e;

  typedef struct packed {
    mfc_fsm_e fsm;
    logic [1:0] cnt;
    mfc_op_e op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [15:0] target;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [15:0] product;
    logic product_we;
    logic done;
    logic busy;
    logic stack_push;
    logic stack_pop;
    logic [15:0] push_data;
    logic wide_en;
    logic unsupported;
    logic [7:0] rd_data;
  } mfc_state_s;

endpackage

// ==== mfc_mul_if.sv ====
// Operand and result bundle between the executor and its multiplier.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/100ps
interface mfc_mul_if;
  logic [7:0] a;
  logic [7:0] b;
  logic signed_a;
  logic signed_b;
  logic frac;
  logic [15:0] product;
  logic zero;
  logic carry;
  modport unit (input a, input b, input signed_a, input signed_b, input frac,
                output product, output zero, output carry);
  modport user (output a, output b, output signed_a, output signed_b, output frac,
                input product, input zero, input carry);
endinterface

// ==== mfc_multiplier.sv ====
// Combinational 8 by 8 multiplier with signed, mixed and fractional forms.
// Assumes the executor holds the operands stable for the whole operation.
`timescale 1ns/100ps
module mfc_multiplier (
  mfc_mul_if.unit m
);
  logic signed [8:0] sa;
  logic signed [8:0] sb;
  logic signed [17:0] full;
  logic [15:0] raw;

  always_comb begin
    sa = {m.signed_a & m.a[7], m.a};
    sb = {m.signed_b & m.b[7], m.b};
    full = sa * sb;
    raw = full[15:0];
  end

  // Carry is taken from the unshifted product so fractional forms keep the sign bit.
  assign m.carry = raw[15];
  assign m.product = m.frac ? {raw[14:0], 1'h0} : raw;
  assign m.zero = (m.product == 16'h0000);
endmodule

// ==== mfc_cond.sv ====
// Branch condition evaluation against the flags register.
// Assumes the flags presented are those in force when the branch starts.
`timescale 1ns/100ps
`include "mfc_defs.svh"
module mfc_cond (
  input wire mfc_pkg::mfc_op_e op,
  input wire logic [7:0] flags,
  input wire logic [2:0] bit_sel,
  output logic taken
);
  always_comb begin
    case (op)
      mfc_pkg::op_branch_on_flag_set: taken = flags[bit_sel];
      mfc_pkg::op_branch_on_flag_clear: taken = !flags[bit_sel];
      mfc_pkg::op_branch_equal: taken = flags[`MFC_FLAG_Z];
      mfc_pkg::op_branch_not_equal: taken = !flags[`MFC_FLAG_Z];
      mfc_pkg::op_branch_carry_set: taken = flags[`MFC_FLAG_C];
      mfc_pkg::op_branch_carry_clear: taken = !flags[`MFC_FLAG_C];
      mfc_pkg::op_branch_unsigned_ge: taken = !flags[`MFC_FLAG_C];
      mfc_pkg::op_branch_unsigned_lt: taken = flags[`MFC_FLAG_C];
      mfc_pkg::op_branch_negative: taken = flags[`MFC_FLAG_N];
      mfc_pkg::op_branch_nonnegative: taken = !flags[`MFC_FLAG_N];
      // The signed test uses N xor V directly, not the stored S bit.
      mfc_pkg::op_branch_signed_ge: taken = !(flags[`MFC_FLAG_N] ^ flags[`MFC_FLAG_V]);
      mfc_pkg::op_branch_signed_lt: taken = flags[`MFC_FLAG_N] ^ flags[`MFC_FLAG_V];
      mfc_pkg::op_branch_half_carry_set: taken = flags[`MFC_FLAG_H];
      mfc_pkg::op_branch_half_carry_clear: taken = !flags[`MFC_FLAG_H];
      mfc_pkg::op_branch_transfer_bit_set: taken = flags[`MFC_FLAG_T];
      mfc_pkg::op_branch_transfer_bit_clear: taken = !flags[`MFC_FLAG_T];
      default: taken = 1'h0;
    endcase
  end
endmodule

// ==== mfc_exec.sv ====
// Execution unit for multiply and program-flow operations of an 8-bit core.
// Assumes a decoder on the same clock gives one start pulse per operation,
// and that stack memory returns the popped word on stack_data by the last cycle.
//
// Behaviour
// - Integer multiplies write product pair, two cycles.
// - Fractional multiplies shift product left one bit.
// - Indirect jump loads pc from Z, two cycles.
// - Indirect call pushes return, loads Z, three cycles.
// - Direct jump and call need wide memory.
// - Equal compare skips next instruction, one-three cycles.
// - Compares subtract, set flags, one cycle.
// - Register bit test skips next instruction.
// - I/O bit test skips next instruction.
// - Generic flag branch goes pc plus offset plus one.
// - Signed branches test N xor V.
// - Unsigned branches mirror the carry branches.
// - Equal branches test the zero flag.
// - Carry branches cost one or two cycles.
// - Sign branches test the negative flag.
// - Half carry branches test half carry flag.
// - Transfer bit branches test the T bit.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`include "mfc_defs.svh"
module mfc_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire mfc_pkg::mfc_op_e op,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] imm,
  input wire logic [15:0] offset,
  input wire logic [15:0] target_addr,
  input wire logic [15:0] z_ptr,
  input wire logic [2:0] bit_sel,
  input wire logic io_bit,
  input wire logic next_two_word,
  input wire logic [15:0] stack_data,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] pc,
  output logic [7:0] flags,
  output logic [15:0] product,
  output logic product_we,
  output logic busy,
  output logic done,
  output logic stack_push,
  output logic stack_pop,
  output logic [15:0] push_data,
  output logic [7:0] reg_rdata
);
  mfc_pkg::mfc_state_s r;
  mfc_pkg::mfc_state_s n;
  mfc_mul_if mul ();
  logic take;
  logic taken;
  logic run_mul;
  logic run_pop;
  logic [2:0] cyc;
  logic [15:0] tgt;
  logic skip;
  logic [7:0] sub_b;
  logic sub_cin;
  logic [8:0] diff;
  logic [7:0] res;
  logic cmp_c;
  logic cmp_h;
  logic cmp_v;
  logic cmp_n;

  mfc_multiplier u_mul (
    .m(mul)
  );

  mfc_cond u_cond (
    .op(op),
    .flags(r.flags),
    .bit_sel(bit_sel),
    .taken(taken)
  );

  assign take = start && (r.fsm == mfc_pkg::fsm_idle);
  assign run_mul = (r.op == mfc_pkg::op_product_unsigned) || (r.op == mfc_pkg::op_product_signed) ||
                   (r.op == mfc_pkg::op_product_mixed_sign) || (r.op == mfc_pkg::op_fraction_product_unsigned) ||
                   (r.op == mfc_pkg::op_fraction_product_signed) ||
                   (r.op == mfc_pkg::op_fraction_product_mixed_sign);
  assign run_pop = (r.op == mfc_pkg::op_subroutine_exit) || (r.op == mfc_pkg::op_interrupt_exit);

  // Operands are latched at start so the multiplier sees stable values for both cycles.
  assign mul.a = r.opa;
  assign mul.b = r.opb;
  assign mul.signed_a = (r.op == mfc_pkg::op_product_signed) || (r.op == mfc_pkg::op_product_mixed_sign) ||
                        (r.op == mfc_pkg::op_fraction_product_signed) ||
                        (r.op == mfc_pkg::op_fraction_product_mixed_sign);
  assign mul.signed_b = (r.op == mfc_pkg::op_product_signed) || (r.op == mfc_pkg::op_fraction_product_signed);
  assign mul.frac = (r.op == mfc_pkg::op_fraction_product_unsigned) ||
                    (r.op == mfc_pkg::op_fraction_product_signed) ||
                    (r.op == mfc_pkg::op_fraction_product_mixed_sign);

  // Compare datapath: a subtraction whose result is thrown away.
  assign sub_b = (op == mfc_pkg::op_compare_immediate) ? imm : rr_val;
  assign sub_cin = (op == mfc_pkg::op_compare_with_borrow) ? r.flags[`MFC_FLAG_C] : 1'h0;
  assign diff = {1'h0, rd_val} - {1'h0, sub_b} - {8'h00, sub_cin};
  assign res = diff[7:0];
  assign cmp_c = diff[8];
  assign cmp_n = res[7];
  assign cmp_h = (!rd_val[3] && sub_b[3]) || (sub_b[3] && res[3]) || (res[3] && !rd_val[3]);
  assign cmp_v = (rd_val[7] && !sub_b[7] && !res[7]) || (!rd_val[7] && sub_b[7] && res[7]);

  always_comb begin
    n = r;
    cyc = `MFC_CYC_ONE;
    tgt = r.pc + `MFC_PC_STEP1;
    skip = 1'h0;
    n.done = 1'h0;
    n.product_we = 1'h0;
    n.stack_push = 1'h0;
    n.stack_pop = 1'h0;
    n.rd_data = 8'h00;

    // Software writes come first so that hardware events in the same cycle win.
    if (reg_we) begin
      case (reg_addr)
        `MFC_REG_CTRL: begin
          n.wide_en = reg_wdata[`MFC_CTRL_WIDE];
          if (reg_wdata[`MFC_CTRL_CLR_ERR]) begin
            n.unsupported = 1'h0;
          end
        end
        `MFC_REG_FLAGS: n.flags = reg_wdata;
        default: n.wide_en = r.wide_en;
      endcase
    end
    if (reg_re) begin
      case (reg_addr)
        `MFC_REG_CTRL: n.rd_data = {7'h00, r.wide_en};
        `MFC_REG_FLAGS: n.rd_data = r.flags;
        `MFC_REG_STATUS: n.rd_data = {6'h00, r.unsupported, r.busy};
        `MFC_REG_PC_LO: n.rd_data = r.pc[7:0];
        `MFC_REG_PC_HI: n.rd_data = r.pc[15:8];
        default: n.rd_data = 8'h00;
      endcase
    end

    case (r.fsm)
      mfc_pkg::fsm_idle: begin
        if (take) begin
          n.op = op;
          n.opa = rd_val;
          n.opb = rr_val;
          case (op)
            mfc_pkg::op_product_unsigned, mfc_pkg::op_product_signed, mfc_pkg::op_product_mixed_sign: begin
              cyc = `MFC_CYC_TWO;
            end
            mfc_pkg::op_fraction_product_unsigned, mfc_pkg::op_fraction_product_signed,
            mfc_pkg::op_fraction_product_mixed_sign: begin
              cyc = `MFC_CYC_TWO;
            end
            mfc_pkg::op_relative_jump: begin
              cyc = `MFC_CYC_TWO;
              tgt = r.pc + `MFC_PC_STEP1 + offset;
            end
            mfc_pkg::op_indirect_jump: begin
              cyc = `MFC_CYC_TWO;
              tgt = z_ptr;
            end
            mfc_pkg::op_relative_subroutine_entry: begin
              cyc = `MFC_CYC_THREE;
              tgt = r.pc + `MFC_PC_STEP1 + offset;
              n.stack_push = 1'h1;
              n.push_data = r.pc + `MFC_PC_STEP1;
            end
            mfc_pkg::op_indirect_subroutine_entry: begin
              cyc = `MFC_CYC_THREE;
              tgt = z_ptr;
              n.stack_push = 1'h1;
              n.push_data = r.pc + `MFC_PC_STEP1;
            end
            // Without the wide memory option these two-word forms are skipped and flagged.
            mfc_pkg::op_direct_jump: begin
              tgt = r.wide_en ? target_addr : r.pc + `MFC_PC_STEP2;
              cyc = r.wide_en ? `MFC_CYC_THREE : `MFC_CYC_ONE;
              // Built on the software-cleared value so a clear is not undone by an unrelated jump.
              n.unsupported = n.unsupported || !r.wide_en;
            end
            mfc_pkg::op_direct_subroutine_entry: begin
              tgt = r.wide_en ? target_addr : r.pc + `MFC_PC_STEP2;
              cyc = r.wide_en ? `MFC_CYC_FOUR : `MFC_CYC_ONE;
              n.unsupported = n.unsupported || !r.wide_en;
              n.stack_push = r.wide_en;
              n.push_data = r.pc + `MFC_PC_STEP2;
            end
            mfc_pkg::op_subroutine_exit, mfc_pkg::op_interrupt_exit: begin
              cyc = `MFC_CYC_FOUR;
              n.stack_pop = 1'h1;
            end
            mfc_pkg::op_compare_regs, mfc_pkg::op_compare_with_borrow, mfc_pkg::op_compare_immediate: begin
              n.flags[`MFC_FLAG_C] = cmp_c;
              n.flags[`MFC_FLAG_N] = cmp_n;
              n.flags[`MFC_FLAG_V] = cmp_v;
              n.flags[`MFC_FLAG_S] = cmp_n ^ cmp_v;
              n.flags[`MFC_FLAG_H] = cmp_h;
              // The borrow form only keeps zero set, so multi-byte compares chain correctly.
              if (op == mfc_pkg::op_compare_with_borrow) begin
                n.flags[`MFC_FLAG_Z] = (res == 8'h00) && r.flags[`MFC_FLAG_Z];
              end else begin
                n.flags[`MFC_FLAG_Z] = (res == 8'h00);
              end
            end
            mfc_pkg::op_compare_skip_equal: skip = (rd_val == rr_val);
            mfc_pkg::op_skip_if_reg_bit_clear: skip = !rd_val[bit_sel];
            mfc_pkg::op_skip_if_reg_bit_set: skip = rd_val[bit_sel];
            mfc_pkg::op_skip_if_io_bit_clear: skip = !io_bit;
            mfc_pkg::op_skip_if_io_bit_set: skip = io_bit;
            default: begin
              if (taken) begin
                cyc = `MFC_CYC_TWO;
                tgt = r.pc + `MFC_PC_STEP1 + offset;
              end
            end
          endcase
          if (skip) begin
            cyc = next_two_word ? `MFC_CYC_THREE : `MFC_CYC_TWO;
            tgt = r.pc + (next_two_word ? `MFC_PC_STEP3 : `MFC_PC_STEP2);
          end
          n.target = tgt;
          if (cyc == `MFC_CYC_ONE) begin
            n.pc = tgt;
            n.done = 1'h1;
          end else begin
            n.fsm = mfc_pkg::fsm_run;
            n.cnt = 2'(cyc - `MFC_CYC_ONE);
            n.busy = 1'h1;
          end
        end
      end
      mfc_pkg::fsm_run: begin
        n.cnt = r.cnt - `MFC_CNT_LAST;
        if (r.cnt == `MFC_CNT_LAST) begin
          n.fsm = mfc_pkg::fsm_idle;
          n.busy = 1'h0;
          n.done = 1'h1;
          n.pc = run_pop ? stack_data : r.target;
          if (run_mul) begin
            n.product = mul.product;
            n.product_we = 1'h1;
            n.flags[`MFC_FLAG_Z] = mul.zero;
            n.flags[`MFC_FLAG_C] = mul.carry;
          end
          if (r.op == mfc_pkg::op_interrupt_exit) begin
            n.flags[`MFC_FLAG_I] = 1'h1;
          end
        end
      end
      default: n.fsm = mfc_pkg::fsm_idle;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
      r.fsm <= mfc_pkg::fsm_idle;
      r.op <= mfc_pkg::op_other;
      r.pc <= `MFC_PC_RESET;
      r.flags <= `MFC_FLAGS_RESET;
      r.wide_en <= `MFC_CTRL_WIDE_RESET;
    end else begin
      r <= n;
    end
  end

  assign pc = r.pc;
  assign flags = r.flags;
  assign product = r.product;
  assign product_we = r.product_we;
  assign busy = r.busy;
  assign done = r.done;
  assign stack_push = r.stack_push;
  assign stack_pop = r.stack_pop;
  assign push_data = r.push_data;
  assign reg_rdata = r.rd_data;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence two_cycle_finish;
    busy ##1 (done && !busy);
  endsequence

  mul_timing_a: assert property (take && op == mfc_pkg::op_product_signed |-> ##1 two_cycle_finish)
    else $error("Multiply did not finish in two cycles.");

  mul_value_a: assert property (take && op == mfc_pkg::op_product_unsigned |->
      ##2 (product_we && product == {8'h00, $past(rd_val, 2)} * {8'h00, $past(rr_val, 2)}))
    else $error("Unsigned product is wrong.");

  frac_value_a: assert property (take && op == mfc_pkg::op_fraction_product_unsigned |->
      ##2 (product == ({8'h00, $past(rd_val, 2)} * {8'h00, $past(rr_val, 2)}) << 1))
    else $error("Fractional product is not shifted.");

  indirect_jump_target_a: assert property (take && op == mfc_pkg::op_indirect_jump |->
      ##1 two_cycle_finish ##0 (pc == $past(z_ptr, 2) && flags == $past(flags, 2)))
    else $error("Indirect jump target or flags wrong.");

  sequence push_then_wait;
    stack_push ##1 busy ##1 done;
  endsequence

  indirect_subroutine_entry_flow_a: assert property (take && op == mfc_pkg::op_indirect_subroutine_entry |->
      ##1 push_then_wait ##0 (pc == $past(z_ptr, 3)))
    else $error("Indirect call did not push and jump in three cycles.");

  direct_gate_a: assert property (take && op == mfc_pkg::op_direct_jump && !r.wide_en |->
      ##1 (done && !busy && pc == $past(pc) + `MFC_PC_STEP2))
    else $error("Direct jump ran without the wide memory option.");

  skip_long_a: assert property (take && op == mfc_pkg::op_compare_skip_equal && rd_val == rr_val &&
      next_two_word |-> ##1 busy [*2] ##1 (done && pc == $past(pc, 3) + `MFC_PC_STEP3))
    else $error("Skip over a two-word instruction is wrong.");

  cmp_carry_a: assert property (take && op == mfc_pkg::op_compare_regs |->
      ##1 (done && flags[`MFC_FLAG_C] == ($past(rd_val) < $past(rr_val))))
    else $error("Compare carry flag is wrong.");

  beq_taken_a: assert property (take && op == mfc_pkg::op_branch_equal && flags[`MFC_FLAG_Z] |->
      ##1 two_cycle_finish ##0 (pc == $past(pc, 2) + `MFC_PC_STEP1 + $past(offset, 2)))
    else $error("Taken equal branch target or timing wrong.");

  blt_skip_a: assert property (take && op == mfc_pkg::op_branch_signed_lt &&
      !(flags[`MFC_FLAG_N] ^ flags[`MFC_FLAG_V]) |-> ##1 (done && pc == $past(pc) + `MFC_PC_STEP1))
    else $error("Untaken signed branch wrong.");

  interrupt_exit_flag_a: assert property (take && op == mfc_pkg::op_interrupt_exit |->
      ##1 stack_pop ##3 (done && flags[`MFC_FLAG_I] && pc == $past(stack_data)))
    else $error("Interrupt exit did not restore pc and set I.");
endmodule

// ==== mfc_stack_model.sv ====
// Stack partner: a small LIFO of return addresses behind the executor.
// Assumes push and pop are one-cycle pulses on the executor's clock.
`timescale 1ns/100ps
module mfc_stack_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [15:0] push_data,
  output logic [15:0] stack_data
);
  logic [15:0] mem [0:7];
  logic [2:0] sp;
  logic [1:0] hold;
  // The popped word holds only while the executor may sample it, then toggles so a late sample shows.
  always_ff @(posedge clock) begin
    if (rst) begin
      sp <= 3'h0;
      hold <= 2'h0;
      stack_data <= 16'h5a5a;
    end else if (push) begin
      mem[sp] <= push_data;
      sp <= sp + 3'h1;
    end else if (pop) begin
      stack_data <= mem[sp - 3'h1];
      sp <= sp - 3'h1;
      hold <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      stack_data <= ~stack_data;
    end
  end
endmodule

// ==== multiply_and_flow_control_exec_bench.sv ====
// Self-checking bench for the multiply and program-flow executor.
// Assumes the stack partner model and the shared package and header.
`timescale 1ns/100ps
`include "mfc_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module multiply_and_flow_control_exec_bench;
  typedef struct {logic [15:0] pc; logic [7:0] fl; logic [15:0] pr; int n;} mfc_note_s;
  logic clock, rst, start, io_bit, next_two_word, reg_we, reg_re, product_we, busy, done, stack_push, stack_pop;
  mfc_pkg::mfc_op_e op;
  logic [7:0] rd_val, rr_val, imm, reg_wdata, flags, reg_rdata, efl, rv;
  logic [15:0] offset, target_addr, z_ptr, stack_data, pc, product, push_data, epc, epr;
  logic [2:0] bit_sel, reg_addr;
  logic wide, rdp = 1'b0;
  mfc_note_s eq[$];
  logic [7:0] rq[$];
  logic [15:0] estk[$];
  int err_count = 0, tests_run = 0, cyc = 0, t0 = 0;
  // Branch table from the flag-set branch onward: tested bit (8 is N xor V) and level that takes it.
  int bi[16] = '{0, 0, 1, 1, 0, 0, 0, 0, 2, 2, 8, 8, 5, 5, 6, 6};
  logic sn[16] = '{1, 0, 1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0};
  mfc_exec mfc_exec_i (.clock, .rst, .start, .op, .rd_val, .rr_val, .imm, .offset, .target_addr, .z_ptr,
    .bit_sel, .io_bit, .next_two_word, .stack_data, .reg_addr, .reg_wdata, .reg_we, .reg_re, .pc, .flags,
    .product, .product_we, .busy, .done, .stack_push, .stack_pop, .push_data, .reg_rdata);
  mfc_stack_model mfc_stack_model_i (.clock, .rst, .push(stack_push), .pop(stack_pop), .push_data, .stack_data);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    if (a == `MFC_REG_FLAGS) efl = d;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_re <= 1'b1;
    rq.push_back(e);
    @(posedge clock);
    reg_re <= 1'b0;
  endtask
  task automatic run_op(mfc_pkg::mfc_op_e o, logic [7:0] a, logic [7:0] b);
    logic [15:0] p, off, z, tg, u;
    logic [8:0] d, fv;
    logic [2:0] bs;
    logic io, tw, sk;
    int n, k, j;
    off = $urandom;
    z = $urandom;
    tg = $urandom;
    bs = $urandom;
    io = $urandom;
    tw = $urandom;
    p = epc + 16'h0001;
    n = 1;
    sk = 1'b0;
    j = int'(o) - 22;
    fv = {efl[2] ^ efl[3], efl};
    if (o <= mfc_pkg::op_fraction_product_mixed_sign) begin
      if (int'(o) % 3 == 0) u = a * b;
      else if (int'(o) % 3 == 1) u = $signed(a) * $signed(b);
      else u = $signed(a) * $signed({1'b0, b});
      epr = (o >= mfc_pkg::op_fraction_product_unsigned) ? {u[14:0], 1'b0} : u;
      efl[1:0] = {epr == 16'h0000, u[15]};
      n = 2;
    end else case (o)
      mfc_pkg::op_relative_jump: {p, n} = {epc + 16'h0001 + off, 32'd2};
      mfc_pkg::op_indirect_jump: {p, n} = {z, 32'd2};
      mfc_pkg::op_direct_jump: {p, n} = wide ? {tg, 32'd3} : {epc + 16'h0002, 32'd1};
      mfc_pkg::op_direct_subroutine_entry: begin
        if (wide) estk.push_back(epc + 16'h0002);
        {p, n} = wide ? {tg, 32'd4} : {epc + 16'h0002, 32'd1};
      end
      mfc_pkg::op_relative_subroutine_entry, mfc_pkg::op_indirect_subroutine_entry: begin
        estk.push_back(epc + 16'h0001);
        {p, n} = {(o == mfc_pkg::op_indirect_subroutine_entry) ? z : epc + 16'h0001 + off, 32'd3};
      end
      mfc_pkg::op_subroutine_exit, mfc_pkg::op_interrupt_exit: begin
        {p, n} = {estk.pop_back(), 32'd4};
        if (o == mfc_pkg::op_interrupt_exit) efl[7] = 1'b1;
      end
      mfc_pkg::op_compare_skip_equal: sk = (a == b);
      mfc_pkg::op_skip_if_reg_bit_clear: sk = !a[bs];
      mfc_pkg::op_skip_if_reg_bit_set: sk = a[bs];
      mfc_pkg::op_skip_if_io_bit_clear: sk = !io;
      mfc_pkg::op_skip_if_io_bit_set: sk = io;
      mfc_pkg::op_compare_regs, mfc_pkg::op_compare_with_borrow, mfc_pkg::op_compare_immediate: begin
        d = {1'b0, a} - {1'b0, b} - ((o == mfc_pkg::op_compare_with_borrow) ? efl[0] : 1'b0);
        efl[1] = (d[7:0] == 8'h00) && (o != mfc_pkg::op_compare_with_borrow || efl[1]);
        efl[0] = d[8];
        efl[2] = d[7];
        efl[3] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
        efl[4] = efl[2] ^ efl[3];
        efl[5] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
      end
      default: if (fv[(j < 2) ? bs : bi[j]] == sn[j]) {p, n} = {epc + 16'h0001 + off, 32'd2};
    endcase
    if (sk) {p, n} = {epc + 16'h0002 + tw, 2 + int'(tw)};
    @(posedge clock);
    {start, rd_val, rr_val, imm, offset, z_ptr, target_addr} <= {1'b1, a, b, b, off, z, tg};
    op <= o;
    {bit_sel, io_bit, next_two_word} <= {bs, io, tw};
    epc = p;
    eq.push_back('{p, efl, epr, n});
    @(posedge clock);
    start <= 1'b0;
    k = 0;
    do @(negedge clock); while (done !== 1'b1 && ++k < 8);
  endtask
  always @(posedge clock) begin
    mfc_note_s e;
    cyc++;
    if (done === 1'b1) begin
      e = eq.pop_front();
      `CHK(pc, e.pc)
      `CHK(flags, e.fl)
      `CHK(product, e.pr)
      `CHK(cyc - t0, e.n)
    end
    if (start && !busy && !rst) t0 = cyc;
    if (rdp) `CHK(reg_rdata, rq.pop_front())
    rdp = reg_re;
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    complete_run();
  end
  initial begin
    {start, io_bit, next_two_word, reg_we, reg_re} = '0;
    op = mfc_pkg::op_other;
    {rd_val, rr_val, imm, reg_wdata, offset, target_addr, z_ptr, bit_sel, reg_addr} = '0;
    {epc, epr, efl, wide} = '0;
    void'($urandom(36620));
    rst = 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(`MFC_REG_CTRL, 8'h00);
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00);
    run_op(mfc_pkg::op_product_signed, 8'h80, 8'h80);
    run_op(mfc_pkg::op_fraction_product_signed, 8'h80, 8'h80);
    for (int i = 0; i < 36; i++) run_op(mfc_pkg::mfc_op_e'(i % 6), $urandom, $urandom);
    for (int i = 0; i < 48; i++) begin
      rv = $urandom;
      run_op(mfc_pkg::mfc_op_e'(14 + i % 8), rv, (i % 3 == 0) ? 8'($urandom) : rv);
    end
    for (int i = 0; i < 64; i++) begin
      wr(`MFC_REG_FLAGS, $urandom);
      run_op(mfc_pkg::mfc_op_e'(22 + i % 16), 8'h00, 8'h00);
    end
    run_op(mfc_pkg::op_relative_jump, 8'h00, 8'h00);
    run_op(mfc_pkg::op_indirect_jump, 8'h00, 8'h00);
    run_op(mfc_pkg::op_direct_jump, 8'h00, 8'h00);
    rd(`MFC_REG_STATUS, 8'h02);
    wr(`MFC_REG_CTRL, 8'h03);
    wide = 1'b1;
    rd(`MFC_REG_STATUS, 8'h00);
    for (int i = 8; i < 14; i++) run_op(mfc_pkg::mfc_op_e'(i), 8'h00, 8'h00);
    for (int i = 0; i < 3; i++) run_op(mfc_pkg::mfc_op_e'((i == 0) ? 10 : 12 + i / 2), 8'h00, 8'h00);
    rd(`MFC_REG_PC_LO, epc[7:0]);
    rd(`MFC_REG_PC_HI, epc[15:8]);
    rd(`MFC_REG_FLAGS, efl);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    {epc, epr, efl, wide} = '0;
    rd(`MFC_REG_FLAGS, 8'h00);
    run_op(mfc_pkg::op_direct_jump, 8'h00, 8'h00);
    repeat (3) @(posedge clock);
    `CHK(eq.size(), 0)
    complete_run();
  end
endmodule
